// ### rtl/i2c_clk_pkg.sv
// constants, field layouts and carrier types for the i2c transfer-clock select block
// assumes one 20 mhz clock and a 32-bit apb register port with byte offsets
package i2c_clk_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_FX = 8'h00;      // i2c_function_expansion
  localparam logic [7:0] OFS_CLSEL = 8'h04;   // clock_selection_register
  localparam logic [7:0] OFS_PRESC = 8'h08;   // shared_prescaler_register
  localparam logic [7:0] OFS_CTRL = 8'h0c;    // controller_control_register
  localparam logic [7:0] OFS_STATUS = 8'h10;  // divisor and serial clock state
  localparam logic [7:0] OFS_BITWR = 8'h14;   // single-bit write port

  // reset values
  localparam logic [7:0] RST_FX = 8'h00;
  localparam logic [7:0] RST_CLSEL = 8'h00;
  localparam logic [7:0] RST_PRESC = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // writable bits, the rest read as zero
  localparam logic [7:0] MASK_FX = 8'h01;
  localparam logic [7:0] MASK_CLSEL = 8'h0b;
  localparam logic [7:0] MASK_PRESC = 8'h13;
  localparam logic [7:0] MASK_CTRL = 8'h80;

  // field positions
  localparam int FX_CLX_BIT = 0;
  localparam int CLSEL_CL0_BIT = 0;
  localparam int CLSEL_CL1_BIT = 1;
  localparam int CLSEL_SMC_BIT = 3;
  localparam int PRESC_OCKS0_BIT = 0;
  localparam int PRESC_OCKS1_BIT = 1;
  localparam int PRESC_HALV_BIT = 4;
  localparam int CTRL_EN_BIT = 7;
  localparam int BITWR_IDX_LSB = 0;
  localparam int BITWR_VAL_BIT = 3;
  localparam int BITWR_SEL_LSB = 4;
  localparam int ST_M_LSB = 0;
  localparam int ST_VALID_BIT = 16;
  localparam int ST_SCL_BIT = 17;
  localparam int ST_EN_BIT = 18;

  // single-bit write target codes
  localparam logic [1:0] SEL_FX = 2'h0;
  localparam logic [1:0] SEL_CLSEL = 2'h1;
  localparam logic [1:0] SEL_PRESC = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;

  // divisor width and table
  localparam int M_W = 10;
  localparam int DIV_N = 16;

  typedef struct packed {
    logic smc;            // speed_mode_select
    logic clx;            // clock_extension_bit, already gated by smc
    logic [1:0] cl;       // clock_select_high, clock_select_low
    logic halv;           // prescaler_halving_bit
    logic [1:0] ocks;     // prescaler_select_high, prescaler_select_low
  } clk_sel_t;

  typedef struct packed {
    logic [6:0] key;
    logic [M_W-1:0] m;
  } div_entry_t;

  localparam div_entry_t DIV_TABLE [DIV_N] = '{
    '{7'h04, 10'd344}, '{7'h05, 10'd516}, '{7'h06, 10'd688}, '{7'h07, 10'd860},
    '{7'h0c, 10'd264}, '{7'h0d, 10'd396}, '{7'h16, 10'd352}, '{7'h17, 10'd440},
    '{7'h10, 10'd88}, '{7'h44, 10'd96}, '{7'h46, 10'd192}, '{7'h47, 10'd240},
    '{7'h64, 10'd72}, '{7'h65, 10'd108}, '{7'h66, 10'd144}, '{7'h68, 10'd120}
  };

  // register file state
  typedef struct packed {
    logic [7:0] fx;
    logic [7:0] clsel;
    logic [7:0] presc;
    logic [7:0] ctrl;
    logic [31:0] rdata;
  } regs_t;

  localparam regs_t REGS_RST = '{RST_FX, RST_CLSEL, RST_PRESC, RST_CTRL, 32'h0000_0000};

  // lookup state
  typedef struct packed {
    logic [M_W-1:0] m;
    logic valid;
  } div_t;

  // serial clock divider state
  typedef struct packed {
    logic [M_W-1:0] cnt;
    logic level;
    logic tick;
  } sclk_t;

endpackage

// ### rtl/i2c_divisor_lookup.sv
// maps the clock selection bits onto one divisor of the allowed set
// assumes the selection struct is stable or changes only between transfers
module i2c_divisor_lookup (
  input wire logic i_mclk,                          // 20 mhz clock
  input wire logic i_rst_n,                         // async reset, active low
  input wire i2c_clk_pkg::clk_sel_t i_sel,          // selection bits
  output logic [i2c_clk_pkg::M_W-1:0] o_m,          // divisor, registered
  output logic o_valid                              // combination supported
);

  i2c_clk_pkg::div_t st_reg;
  i2c_clk_pkg::div_t st_next;
  logic [i2c_clk_pkg::DIV_N-1:0] hit;
  logic [i2c_clk_pkg::M_W-1:0] pick [i2c_clk_pkg::DIV_N];

  // one comparator per table entry
  genvar g;
  generate
    for (g = 0; g < i2c_clk_pkg::DIV_N; g++)
    begin : g_ent
      assign hit[g] = (i_sel == i2c_clk_pkg::DIV_TABLE[g].key);
      assign pick[g] = hit[g] ? i2c_clk_pkg::DIV_TABLE[g].m : '0;
    end
  endgenerate

  // or of the single matching entry; no match means unsupported
  always_comb
  begin
    st_next.m = '0;
    for (int i = 0; i < i2c_clk_pkg::DIV_N; i++)
    begin
      st_next.m = st_next.m | pick[i];
    end
    st_next.valid = |hit;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_m = st_reg.m;
  assign o_valid = st_reg.valid;

endmodule

// ### rtl/i2c_scl_divider.sv
// serial clock period generator: one period is m cycles of the clock
// assumes m changes only while i_run is low
module i2c_scl_divider #(
  parameter int CNT_W = 10                          // counter width
) (
  input wire logic i_mclk,                          // 20 mhz clock
  input wire logic i_rst_n,                         // async reset, active low
  input wire logic i_run,                           // enable and valid divisor
  input wire logic [CNT_W-1:0] i_m,                 // period in clock cycles
  output logic o_tick,                              // one-cycle pulse per period
  output logic o_level                              // scl level, low half first
);

  // refuse a counter too narrow for the largest divisor
  generate
    if (CNT_W < i2c_clk_pkg::M_W)
    begin : g_chk
      $error("i2c_scl_divider: CNT_W too small");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic level;
    logic tick;
  } st_t;

  st_t st_reg;
  st_t st_next;
  logic wrap;
  logic [CNT_W-1:0] half;

  // count 0..m-1, low for the first half, pulse on wrap
  always_comb
  begin
    st_next = st_reg;
    half = i_m >> 1;
    wrap = (st_reg.cnt == i_m - CNT_W'(1));
    if (!i_run)
    begin
      st_next.cnt = '0;
      st_next.level = 1'b1;
      st_next.tick = 1'b0;
    end
    else
    begin
      st_next.cnt = wrap ? '0 : st_reg.cnt + CNT_W'(1);
      st_next.tick = wrap;
      st_next.level = ~wrap & (st_next.cnt >= half);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '{'0, 1'b1, 1'b0};
    else
      st_reg <= st_next;
  end

  assign o_tick = st_reg.tick;
  assign o_level = st_reg.level;

endmodule

// ### rtl/i2c_transfer_clock_select.sv
// register file and serial clock selection of the i2c controller
// assumes an apb master on a single 20 mhz clock, byte data in the low lane

module i2c_transfer_clock_select (
  input wire logic i_mclk,                          // 20 mhz clock
  input wire logic i_rst_n,                         // async reset, active low
  input wire logic i_psel,                          // apb select
  input wire logic i_penable,                       // apb enable
  input wire logic i_pwrite,                        // apb direction
  input wire logic [7:0] i_paddr,                   // apb byte address
  input wire logic [31:0] i_pwdata,                 // apb write data
  input wire logic [3:0] i_pstrb,                   // apb byte strobes
  output logic o_pready,                            // apb ready
  output logic [31:0] o_prdata,                     // apb read data
  output logic o_pslverr,                           // apb error, unmapped address
  output logic [i2c_clk_pkg::M_W-1:0] o_divisor,    // selected divisor m
  output logic o_divisor_valid,                     // combination supported
  output logic o_scl_tick,                          // pulse once per scl period
  output logic o_scl_level                          // scl level from the divider
);

  i2c_clk_pkg::regs_t st_reg;
  i2c_clk_pkg::regs_t st_next;
  i2c_clk_pkg::clk_sel_t sel;
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic en;
  logic run;
  logic [31:0] rd_word;
  logic [2:0] bit_idx;
  logic bit_val;
  logic [1:0] bit_sel;

  // one bit replaced, reserved bits kept at zero
  function automatic logic [7:0] put_bit(input logic [7:0] cur, input logic [2:0] idx,
                                         input logic val, input logic [7:0] mask);
    logic [7:0] tmp;
    tmp = cur;
    tmp[idx] = val;
    return tmp & mask;
  endfunction

  // apb phases and address decode
  always_comb
  begin
    setup = i_psel & ~i_penable;
    access = i_psel & i_penable;
    if (i_paddr == i2c_clk_pkg::OFS_FX)
      mapped = 1'b1;
    else if (i_paddr == i2c_clk_pkg::OFS_CLSEL)
      mapped = 1'b1;
    else if (i_paddr == i2c_clk_pkg::OFS_PRESC)
      mapped = 1'b1;
    else if (i_paddr == i2c_clk_pkg::OFS_CTRL)
      mapped = 1'b1;
    else if (i_paddr == i2c_clk_pkg::OFS_STATUS)
      mapped = 1'b1;
    else if (i_paddr == i2c_clk_pkg::OFS_BITWR)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign wr = access & mapped & i_pwrite & i_pstrb[0];
  assign en = st_reg.ctrl[i2c_clk_pkg::CTRL_EN_BIT];
  assign bit_idx = i_pwdata[i2c_clk_pkg::BITWR_IDX_LSB +: 3];
  assign bit_val = i_pwdata[i2c_clk_pkg::BITWR_VAL_BIT];
  assign bit_sel = i_pwdata[i2c_clk_pkg::BITWR_SEL_LSB +: 2];

  // read multiplexer, low byte carries the 8-bit registers
  always_comb
  begin
    rd_word = '0;
    if (i_paddr == i2c_clk_pkg::OFS_FX)
      rd_word[7:0] = st_reg.fx;
    else if (i_paddr == i2c_clk_pkg::OFS_CLSEL)
      rd_word[7:0] = st_reg.clsel;
    else if (i_paddr == i2c_clk_pkg::OFS_PRESC)
      rd_word[7:0] = st_reg.presc;
    else if (i_paddr == i2c_clk_pkg::OFS_CTRL)
      rd_word[7:0] = st_reg.ctrl;
    else if (i_paddr == i2c_clk_pkg::OFS_STATUS)
    begin
      rd_word[i2c_clk_pkg::ST_M_LSB +: i2c_clk_pkg::M_W] = o_divisor;
      rd_word[i2c_clk_pkg::ST_VALID_BIT] = o_divisor_valid;
      rd_word[i2c_clk_pkg::ST_SCL_BIT] = o_scl_level;
      rd_word[i2c_clk_pkg::ST_EN_BIT] = en;
    end
  end

  // register writes at the access edge; read data captured in setup
  always_comb
  begin
    st_next = st_reg;
    if (setup)
      st_next.rdata = i_pwrite ? 32'h0000_0000 : rd_word;
    if (wr)
    begin
      if (i_paddr == i2c_clk_pkg::OFS_FX)
      begin
        if (!en)
          st_next.fx = i_pwdata[7:0] & i2c_clk_pkg::MASK_FX;
      end
      else if (i_paddr == i2c_clk_pkg::OFS_CLSEL)
        st_next.clsel = i_pwdata[7:0] & i2c_clk_pkg::MASK_CLSEL;
      else if (i_paddr == i2c_clk_pkg::OFS_PRESC)
        st_next.presc = i_pwdata[7:0] & i2c_clk_pkg::MASK_PRESC;
      else if (i_paddr == i2c_clk_pkg::OFS_CTRL)
        st_next.ctrl = i_pwdata[7:0] & i2c_clk_pkg::MASK_CTRL;
      else if (i_paddr == i2c_clk_pkg::OFS_BITWR)
      begin
        case (bit_sel)
          i2c_clk_pkg::SEL_FX:
          begin
            if (!en)
              st_next.fx = put_bit(st_reg.fx, bit_idx, bit_val, i2c_clk_pkg::MASK_FX);
          end
          i2c_clk_pkg::SEL_CLSEL:
            st_next.clsel = put_bit(st_reg.clsel, bit_idx, bit_val, i2c_clk_pkg::MASK_CLSEL);
          i2c_clk_pkg::SEL_PRESC:
            st_next.presc = put_bit(st_reg.presc, bit_idx, bit_val, i2c_clk_pkg::MASK_PRESC);
          default:
            st_next.ctrl = put_bit(st_reg.ctrl, bit_idx, bit_val, i2c_clk_pkg::MASK_CTRL);
        endcase
      end
    end
  end

  // register state, cleared by reset
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= i2c_clk_pkg::REGS_RST;
    else
      st_reg <= st_next;
  end

  // selection bits gathered; extension masked outside high-speed mode
  always_comb
  begin
    sel.smc = st_reg.clsel[i2c_clk_pkg::CLSEL_SMC_BIT];
    sel.clx = st_reg.fx[i2c_clk_pkg::FX_CLX_BIT] & sel.smc;
    sel.cl = {st_reg.clsel[i2c_clk_pkg::CLSEL_CL1_BIT], st_reg.clsel[i2c_clk_pkg::CLSEL_CL0_BIT]};
    sel.halv = st_reg.presc[i2c_clk_pkg::PRESC_HALV_BIT];
    sel.ocks = {st_reg.presc[i2c_clk_pkg::PRESC_OCKS1_BIT], st_reg.presc[i2c_clk_pkg::PRESC_OCKS0_BIT]};
  end

  i2c_divisor_lookup u_lookup (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_sel(sel),
    .o_m(o_divisor),
    .o_valid(o_divisor_valid)
  );

  // divider runs only while enabled with a supported divisor
  assign run = en & o_divisor_valid;

  i2c_scl_divider #(
    .CNT_W(i2c_clk_pkg::M_W)
  ) u_div (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_run(run),
    .i_m(o_divisor),
    .o_tick(o_scl_tick),
    .o_level(o_scl_level)
  );

  // apb answers: zero wait states, error on unmapped address
  assign o_pready = access;
  assign o_pslverr = access & ~mapped;
  assign o_prdata = st_reg.rdata;

endmodule

// ### tb/i2c_tcs_sva.sv
// assertions on the transfer clock select ports
// assumes binding onto the block's top module
module i2c_tcs_sva (
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic o_pready, // apb ready
  input wire logic [31:0] o_prdata, // read data
  input wire logic [i2c_clk_pkg::M_W-1:0] o_divisor, // divisor
  input wire logic o_divisor_valid, // supported
  input wire logic o_scl_tick // period pulse
);
  logic [9:0] gap_reg;
  logic armed_reg;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // cycles since the last pulse; armed only inside one run
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gap_reg <= 10'h000;
      armed_reg <= 1'b0;
    end
    else
    begin
      gap_reg <= o_scl_tick ? 10'h000 : gap_reg + 10'h001;
      armed_reg <= o_scl_tick | (armed_reg & (gap_reg < o_divisor));
    end
  end
  a_reset_clear: assert property (disable iff (1'b0) !i_rst_n |-> !o_divisor_valid && o_divisor == 10'h000)
    else $error("divisor not cleared in reset");
  a_period_len: assert property (o_scl_tick && armed_reg |-> gap_reg == o_divisor - 10'h001)
    else $error("period differs from divisor");
  a_tick_single: assert property (o_scl_tick |=> !o_scl_tick)
    else $error("pulse longer than a cycle");
  a_div_set: assert property (o_divisor_valid ? o_divisor inside {10'd72, 10'd88, 10'd96, 10'd108, 10'd120,
    10'd144, 10'd192, 10'd240, 10'd264, 10'd344, 10'd352, 10'd396, 10'd440, 10'd516, 10'd688, 10'd860}
    : o_divisor == 10'h000)
    else $error("divisor outside the allowed set");
  a_tick_valid: assert property (o_scl_tick |-> o_divisor_valid && $stable(o_divisor))
    else $error("pulse without a valid divisor");
  a_ready_access: assert property (i_psel && i_penable |-> o_pready)
    else $error("no ready in access phase");
  a_read_hold: assert property (i_psel && i_penable |=> $stable(o_prdata))
    else $error("read data moved after access");
endmodule
bind i2c_transfer_clock_select i2c_tcs_sva i_i2c_tcs_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_divisor(o_divisor), .o_divisor_valid(o_divisor_valid), .o_scl_tick(o_scl_tick));

// ### tb/i2c_bus_listener.sv
// bus device that times serial clock periods
// assumes the level is sampled on the system clock
module i2c_bus_listener (
  input wire logic i_mclk, // system clock
  input wire logic i_scl, // serial clock level
  output int o_period, // cycles between rises
  output int o_rises // rises seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b1;
  int cnt = 0;
  initial o_period = 0;
  initial o_rises = 0;
  // period from one rising edge to the next
  always @(posedge i_mclk)
  begin
    cnt <= cnt + 1;
    prev <= i_scl;
    if (i_scl && !prev)
    begin
      o_period <= cnt + 1;
      o_rises <= o_rises + 1;
      cnt <= 0;
    end
  end
endmodule

// ### tb/i2c_transfer_clock_select_tb_top.sv
// self-checking bench for the transfer clock select block
// assumes package, block, checker and listener compiled first
module i2c_transfer_clock_select_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_rst_n, psel, penable, pwrite, pready, pslverr, tick, level, dvalid, err;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] divisor;
  logic [6:0] pk [2] = '{7'h64, 7'h07};
  int errors = 0, samples_checked = 0, cycles = 0, period, rises, n, m;

  i2c_transfer_clock_select i_i2c_transfer_clock_select (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .o_divisor(divisor), .o_divisor_valid(dvalid), .o_scl_tick(tick), .o_scl_level(level));
  i2c_bus_listener i_i2c_bus_listener (.i_mclk(i_mclk), .i_scl(level), .o_period(period),
    .o_rises(rises));

  // 20 mhz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'($urandom) | 4'h1;
    @(posedge i_mclk);
    penable <= 1'b1;
    do
      @(posedge i_mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // divisor expected for a selection key
  function automatic int model_m(input logic [6:0] k);
    model_m = 0;
    for (int i = 0; i < i2c_clk_pkg::DIV_N; i++)
      if (i2c_clk_pkg::DIV_TABLE[i].key == {k[6], k[5] & k[6], k[4:0]})
        model_m = int'(i2c_clk_pkg::DIV_TABLE[i].m);
  endfunction

  // key bits: speed, extension, selects, halving, prescaler; junk in unused bits
  task automatic set_key(input logic [6:0] k);
    apb(1'b1, 8'h00, ($urandom & ~32'h1) | 32'(k[5]));
    apb(1'b1, 8'h04, ($urandom & ~32'hb) | 32'({k[6], 1'b0, k[4:3]}));
    apb(1'b1, 8'h08, ($urandom & ~32'h13) | 32'({k[2], 2'b00, k[1:0]}));
  endtask

  // give up on a hang
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, i_rst_n} = '0;
    void'($urandom(71413));
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // reset values, then an unmapped place
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    // byte write, then one refused while enabled
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h0c, 32'h80);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check("expansion held", rd, 32'h1);
    // single-bit writes: enable off, extension clear then set
    apb(1'b1, 8'h14, 32'h37);
    apb(1'b1, 8'h14, 32'h00);
    apb(1'b0, 8'h00, 32'h0);
    check("bit clear", rd, 32'h0);
    apb(1'b1, 8'h14, 32'h08);
    apb(1'b0, 8'h00, 32'h0);
    check("bit set", rd, 32'h1);
    // every selection combination
    for (int i = 0; i < 128; i++)
    begin
      set_key(7'(i));
      repeat (2) @(posedge i_mclk);
      m = model_m(7'(i));
      check("divisor", 32'(divisor), 32'(m));
      check("valid", 32'(dvalid), 32'(m != 0));
      apb(1'b0, 8'h10, 32'h0);
      check("status", rd & 32'h0007_ffff, {13'h0, 1'b0, 1'b1, 1'(m != 0), 6'h0, 10'(m)});
    end
    // shortest and longest periods on the serial clock
    for (int j = 0; j < 2; j++)
    begin
      set_key(pk[j]);
      apb(1'b1, 8'h0c, 32'h80);
      n = rises;
      while (rises < n + 3)
        @(posedge i_mclk);
      check("scl period", 32'(period), 32'(model_m(pk[j])));
      apb(1'b1, 8'h0c, 32'h0);
    end
    conclude();
  end
endmodule
